// ==== apfls_pkg.sv ====
// package of constants for the audio port frame load sync core
//
// Function
// - all timing comes from the master timing clock, nothing else.
// - internal frame clock always runs at 128 times the sample rate.
// - programmable variant divides the master clock down to 128 Fs first.
// - after reset align timing to frame marker so A is left, B is right.
// - frame marker drifting against internal clock causes an internal reset.
// - bits shift into input register; port load copies it and latches C, U, V.
// - C, U, V come from memory in one variant, from pins in the other.
// - port load rises on the first bit clock edge that latches data.
// - port load stays high exactly one bit clock period.
// - after preamble, shifter load copies holding buffer into output register.
// - port load overlapping shifter load starts an internal reset.
// - in CD submode subcode bit clock is port load gated by subcode frame clock.
// - while reset is low counters clear, tick position loads 64 and line drivers are driven low.
// - as bit clock output, produce 32 bit clocks per audio sample.
// - validity sampled once per subframe; 1 marks audio invalid.
package apfls_pkg;
  localparam int unsigned WORD_W      = 24;
  localparam int unsigned SUBFR_TICKS = 64;   // 128 Fs ticks per subframe
  localparam int unsigned FRAME_TICKS = 128;  // 128 Fs ticks per frame
  localparam int unsigned BCLK_DIV    = 2;    // 128 Fs / 64 = 2 ticks per bit clock half
  localparam int unsigned PRE_TICKS   = 8;    // preamble length in ticks
  localparam logic [2:0]  MASTER_DIV_RST = 3'h0; // divide-by-one default
  typedef enum logic [1:0] {APFLS_WAIT, APFLS_RUN, APFLS_RESYNC} apfls_state_e;
endpackage

// ==== apfls_div.sv ====
// master clock divider producing a 128 Fs tick
`timescale 1ns/1ps
module apfls_div
  import apfls_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic [2:0] ratio_i,
  output logic            tick_o
);
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [7:0] limit;
  // ratio selects divide by 2^ratio so the tick is always 128 Fs
  assign limit   = 8'((9'h1 << ratio_i) - 9'h1);
  assign nxt_cnt = (cnt_ff >= limit) ? 8'h00 : cnt_ff + 8'h01;
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      cnt_ff <= 8'h00;
      tick_o <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      tick_o <= (cnt_ff >= limit);
    end
  end
endmodule

// ==== apfls_top.sv ====
// audio port to transmit shifter load and frame sync core
`timescale 1ns/1ps
module apfls_top
  import apfls_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic [2:0]        master_ratio_i,
  input  wire logic              bit_clock_i,
  input  wire logic              frame_marker_i,
  input  wire logic              serial_audio_in_i,
  input  wire logic              chan_status_i,
  input  wire logic              user_i,
  input  wire logic              validity_i,
  input  wire logic              cuv_from_mem_i,
  input  wire logic [2:0]        mem_cuv_i,
  input  wire logic              cd_submode_i,
  input  wire logic              subcode_frame_clock_i,
  output logic                   bit_clock_o,
  output logic                   port_load_strobe_o,
  output logic                   shifter_load_strobe_o,
  output logic                   subcode_bit_clock_o,
  output logic [WORD_W-1:0]      output_shift_reg_o,
  output logic [2:0]             out_cuv_o,
  output logic                   channel_b_o,
  output logic                   sync_lost_o,
  output logic                   line_drv_p_o,
  output logic                   line_drv_n_o
);
  // ----------------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------------
  logic [2:0] sck_sy_ff;
  logic [2:0] fm_sy_ff;
  logic [2:0] sd_sy_ff;
  logic [2:0] subfr_sy_ff;
  logic       sck_ff;
  logic       fm_ff;
  logic       subfr_ff;
  logic       nxt_sck;
  logic       nxt_fm;
  logic       nxt_subfr;

  // a level counts once the second and third stage agree, so one runt sample is ignored
  function automatic logic settle(input logic [2:0] s, input logic old);
    settle = (s[2] == s[1]) ? s[1] : old;
  endfunction

  always_ff @(posedge ref_clk_i)
  begin
    sck_sy_ff   <= {sck_sy_ff[1:0], bit_clock_i};
    fm_sy_ff    <= {fm_sy_ff[1:0], frame_marker_i};
    sd_sy_ff    <= {sd_sy_ff[1:0], serial_audio_in_i};
    subfr_sy_ff <= {subfr_sy_ff[1:0], subcode_frame_clock_i};
  end

  assign nxt_sck   = settle(sck_sy_ff, sck_ff);
  assign nxt_fm    = settle(fm_sy_ff, fm_ff);
  assign nxt_subfr = settle(subfr_sy_ff, subfr_ff);

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      sck_ff   <= 1'b0;
      fm_ff    <= 1'b0;
      subfr_ff <= 1'b0;
    end
    else
    begin
      sck_ff   <= nxt_sck;
      fm_ff    <= nxt_fm;
      subfr_ff <= nxt_subfr;
    end
  end

  // ----------------------------------------------------------------------
  // internal 128 Fs timing
  // ----------------------------------------------------------------------
  logic tick;
  apfls_div u_div (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .ratio_i   (master_ratio_i),
    .tick_o    (tick)
  );

  apfls_state_e state_ff;
  apfls_state_e nxt_state;
  logic [6:0]   tpos_ff;
  logic [6:0]   nxt_tpos;
  logic         running;
  logic         int_rst;
  logic         sck_rise;
  logic         fm_rise;
  logic         fm_edge;
  logic         load_start;
  logic         shift_now;
  logic         fm_seen_ff;
  logic         nxt_fm_seen;

  assign running    = (state_ff == APFLS_RUN);
  assign sck_rise   = nxt_sck & ~sck_ff;
  assign fm_rise    = nxt_fm & ~fm_ff;
  // either marker edge opens a word, so every subframe gets its own port load
  assign fm_edge    = nxt_fm ^ fm_ff;
  // the load waits for the next bit clock rise so the first bit latched is the msb
  assign load_start = sck_rise & fm_seen_ff;
  assign shift_now  = tick && running
                      && (tpos_ff[5:0] == 6'(PRE_TICKS - 1));
  // a drift that makes both loads coincide corrupts the shifter load, so restart
  assign int_rst    = shift_now & (load_start | port_load_strobe_o);
  // a new marker edge wins over a pending load, it starts a fresh word
  assign nxt_fm_seen = fm_edge ? 1'b1 : (load_start ? 1'b0 : fm_seen_ff);
  // the marker rise opens the right half, so the left word done at the fall lands in A
  assign nxt_tpos   = !running ? 7'(SUBFR_TICKS)
                      : (tick ? 7'((32'(tpos_ff) + 1) % FRAME_TICKS) : tpos_ff);

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      APFLS_WAIT:   if (fm_rise) nxt_state = APFLS_RUN;
      APFLS_RUN:    if (int_rst) nxt_state = APFLS_RESYNC;
      APFLS_RESYNC: nxt_state = APFLS_WAIT;
      default:      nxt_state = APFLS_WAIT;
    endcase
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      state_ff    <= APFLS_WAIT;
      tpos_ff     <= 7'(SUBFR_TICKS);
      fm_seen_ff  <= 1'b0;
      channel_b_o <= 1'b0;
      sync_lost_o <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      tpos_ff     <= nxt_tpos;
      fm_seen_ff  <= nxt_fm_seen;
      channel_b_o <= running && (tpos_ff >= 7'(SUBFR_TICKS));
      sync_lost_o <= int_rst;
    end
  end

  // ----------------------------------------------------------------------
  // generated bit clock
  // ----------------------------------------------------------------------
  logic bdiv_ff;
  logic bit_toggle;

  // half period of two ticks gives 32 bit clocks per sample period
  assign bit_toggle = tick && (bdiv_ff == 1'(BCLK_DIV - 1));

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      bdiv_ff     <= 1'b0;
      bit_clock_o <= 1'b0;
    end
    else
    begin
      if (tick)
        bdiv_ff <= ~bdiv_ff;
      if (bit_toggle)
        bit_clock_o <= ~bit_clock_o;
    end
  end

  // ----------------------------------------------------------------------
  // shift path
  // ----------------------------------------------------------------------
  logic [WORD_W-1:0] input_shift_reg_ff;
  logic [WORD_W-1:0] holding_buffer_ff;
  logic [2:0]        held_cuv_ff;
  logic [2:0]        cuv_src;
  logic [4:0]        bcnt_ff;
  logic              word_open;
  logic              load_out;

  assign cuv_src   = cuv_from_mem_i ? mem_cuv_i
                     : {chan_status_i, user_i, validity_i};
  // bits past the word width are padding and must not push the msb out
  assign word_open = load_start | (sck_rise & (bcnt_ff < 5'(WORD_W)));
  assign load_out  = shift_now & ~int_rst;

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      input_shift_reg_ff <= '0;
      bcnt_ff            <= 5'h00;
    end
    else
    begin
      if (word_open)
        input_shift_reg_ff <= {input_shift_reg_ff[WORD_W-2:0], sd_sy_ff[2]};
      if (load_start)
        bcnt_ff <= 5'h01;
      else if (word_open)
        bcnt_ff <= bcnt_ff + 5'h01;
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      holding_buffer_ff <= '0;
      held_cuv_ff       <= 3'h0;
    end
    else if (load_start)
    begin
      holding_buffer_ff <= input_shift_reg_ff;
      held_cuv_ff       <= cuv_src;
    end
  end

  // ----------------------------------------------------------------------
  // strobes
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      port_load_strobe_o    <= 1'b0;
      subcode_bit_clock_o   <= 1'b0;
      shifter_load_strobe_o <= 1'b0;
    end
    else
    begin
      // strobe spans from one bit clock rise to the next
      if (load_start)
        port_load_strobe_o <= 1'b1;
      else if (sck_rise)
        port_load_strobe_o <= 1'b0;
      subcode_bit_clock_o   <= cd_submode_i & port_load_strobe_o & ~subfr_ff;
      shifter_load_strobe_o <= load_out;
    end
  end

  // ----------------------------------------------------------------------
  // output register and line drivers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_b_i)
    begin
      output_shift_reg_o <= '0;
      out_cuv_o          <= 3'h0;
      line_drv_p_o       <= 1'b0;
      line_drv_n_o       <= 1'b0;
    end
    else
    begin
      if (load_out)
      begin
        output_shift_reg_o <= holding_buffer_ff;
        out_cuv_o          <= held_cuv_ff;
      end
      // drivers stay low until timing is aligned, so no half frame reaches the line
      line_drv_p_o <= running & output_shift_reg_o[WORD_W-1];
      line_drv_n_o <= running & ~output_shift_reg_o[WORD_W-1];
    end
  end
endmodule

// ==== apfls_top_sva.sv ====
// port checker of the frame load sync core
`timescale 1ns/1ps
module apfls_top_sva
(
  input wire logic ref_clk_i,
  input wire logic rst_b_i,
  input wire logic bit_clock_i,
  input wire logic bit_clock_o,
  input wire logic port_load_strobe_o,
  input wire logic shifter_load_strobe_o,
  input wire logic subcode_bit_clock_o,
  input wire logic sync_lost_o,
  input wire logic line_drv_p_o,
  input wire logic line_drv_n_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // ----
  // properties
  // ----
  a_rst_drv_low: assert property (disable iff (1'b0)
    !rst_b_i |=> !(line_drv_p_o | line_drv_n_o)) else $error("driver on in reset");
  a_rst_strb_clr: assert property (disable iff (1'b0)
    !rst_b_i |=> !(port_load_strobe_o | shifter_load_strobe_o)) else $error("strobe in reset");
  a_shl_one_cycle: assert property (shifter_load_strobe_o |=> !shifter_load_strobe_o)
    else $error("shifter load too long");
  a_pls_bit_period: assert property ($rose(port_load_strobe_o) |-> port_load_strobe_o[*8])
    else $error("port load too short");
  a_pls_on_rise: assert property ($rose(port_load_strobe_o) |-> $past(bit_clock_i, 3))
    else $error("port load without bit clock rise");
  a_subclk_from_load: assert property (subcode_bit_clock_o |->
    port_load_strobe_o || $past(port_load_strobe_o)) else $error("subcode clock off load");
  a_lost_drv_off: assert property (sync_lost_o |-> ##[1:2]
    !(line_drv_p_o | line_drv_n_o)) else $error("drivers on after sync loss");
  a_bclk_half: assert property ($changed(bit_clock_o) |=>
    $stable(bit_clock_o)[*7] ##1 $changed(bit_clock_o)) else $error("bit clock half wrong");
  c_port_load: cover property ($rose(port_load_strobe_o));
  c_sync_lost: cover property (sync_lost_o);
  c_subcode: cover property (subcode_bit_clock_o);
endmodule
bind apfls_top apfls_top_sva i_apfls_top_sva (.*);

// ==== apfls_src_model.sv ====
// audio source serial port model
`timescale 1ns/1ps
module apfls_src_model
  import apfls_pkg::*;
(
  input  wire logic              ref_clk_i,
  input  wire logic              run_i,
  input  wire logic              slip_i,
  input  wire logic [WORD_W-1:0] left_i,
  input  wire logic [WORD_W-1:0] right_i,
  output logic                   bit_clk_o,
  output logic                   marker_o,
  output logic                   data_o
);
  // 64 bits of 8 ref cycles fill one frame at divide by 4
  logic [WORD_W-1:0] word;
  initial
  begin
    bit_clk_o = 1'b0;
    marker_o = 1'b0;
    data_o = 1'b0;
    @(negedge ref_clk_i);
    forever
    begin
      if (!run_i)
        @(negedge ref_clk_i);
      for (int b = 0; run_i && b < 64; b++)
      begin
        word = (b < 32) ? left_i : right_i;
        marker_o = (b < 32);
        data_o = (b % 32 < WORD_W) ? word[WORD_W-1-b%32] : ~data_o;
        repeat (4) @(negedge ref_clk_i);
        bit_clk_o = 1'b1;
        // a slip stretches one bit a frame, walking the marker 8 cycles per frame
        repeat (4 + ((slip_i && b == 63) ? 8 : 0)) @(negedge ref_clk_i);
        bit_clk_o = 1'b0;
      end
    end
  end
endmodule

// ==== apfls_top_tb.sv ====
// self-checking bench of the frame load sync core
`timescale 1ns/1ps
module apfls_top_tb
  import apfls_pkg::*;
;
  logic              ref_clk_i, rst_b_i, bit_clock_i, frame_marker_i, serial_audio_in_i;
  logic              chan_status_i, user_i, validity_i, cuv_from_mem_i, cd_submode_i;
  logic              subcode_frame_clock_i, bit_clock_o, port_load_strobe_o, run, slip, hit;
  logic              shifter_load_strobe_o, subcode_bit_clock_o, channel_b_o, sync_lost_o;
  logic              line_drv_p_o, line_drv_n_o;
  logic [2:0]        master_ratio_i, mem_cuv_i, out_cuv_o, cuv;
  logic [WORD_W-1:0] output_shift_reg_o, lw, rw;
  int                n_errors, checks_done;
  apfls_top i_apfls_top (.*);
  apfls_src_model i_src (.ref_clk_i, .run_i(run), .slip_i(slip), .left_i(lw), .right_i(rw),
    .bit_clk_o(bit_clock_i), .marker_o(frame_marker_i), .data_o(serial_audio_in_i));
  task automatic chk(string what, logic [WORD_W-1:0] exp, logic [WORD_W-1:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    if (n_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  function automatic logic [WORD_W-1:0] exp_word(logic chan_b);
    return chan_b ? rw : lw;
  endfunction
  task automatic watch(int n, logic lost);
    hit = 1'b0;
    repeat (n)
    begin
      @(negedge ref_clk_i);
      hit |= lost ? sync_lost_o : subcode_bit_clock_o;
    end
  endtask
  task automatic phase(logic m, logic [WORD_W-1:0] l, logic [WORD_W-1:0] r);
    logic prev_b;
    prev_b = 1'b0;
    @(negedge ref_clk_i);
    {lw, rw, cuv_from_mem_i, cuv, mem_cuv_i} = {l, r, m, 3'($urandom), 3'($urandom)};
    {chan_status_i, user_i, validity_i} = cuv;
    repeat (1536) @(negedge ref_clk_i);
    for (int k = 0; k < 4; k++)
    begin
      for (int i = 0; i < 600 && shifter_load_strobe_o !== 1'b1; i++)
        @(negedge ref_clk_i);
      chk("shift load", WORD_W'(1), WORD_W'(shifter_load_strobe_o));
      @(negedge ref_clk_i);
      if (k > 0)
        chk("channel", WORD_W'(!prev_b), WORD_W'(channel_b_o));
      prev_b = channel_b_o;
      chk("word", exp_word(channel_b_o), output_shift_reg_o);
      chk("cuv", WORD_W'(m ? mem_cuv_i : cuv), WORD_W'(out_cuv_o));
    end
  endtask
  initial
  begin
    ref_clk_i = 1'b0;
    forever
      #12.5 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    #1500000;
    n_errors++;
    test_done();
  end
  initial
  begin
    void'($urandom(32'h3146));
    {rst_b_i, run, slip, cd_submode_i, subcode_frame_clock_i, cuv_from_mem_i} = 6'h00;
    {chan_status_i, user_i, validity_i, mem_cuv_i, lw, rw} = '0;
    master_ratio_i = 3'h2;
    n_errors = 0;
    checks_done = 0;
    repeat (3) @(negedge ref_clk_i);
    chk("drive", '0, WORD_W'(line_drv_p_o | line_drv_n_o));
    rst_b_i = 1'b1;
    run = 1'b1;
    phase(1'b0, 24'hFFFFFF, 24'h000000);
    phase(1'b1, 24'h800001, 24'h7FFFFE);
    repeat (2)
      phase(1'($urandom), WORD_W'($urandom), WORD_W'($urandom));
    cd_submode_i = 1'b1;
    watch(512, 1'b0);
    chk("subcode", WORD_W'(1), WORD_W'(hit));
    subcode_frame_clock_i = 1'b1;
    repeat (8) @(negedge ref_clk_i);
    watch(512, 1'b0);
    chk("subcode gated", '0, WORD_W'(hit));
    {cd_submode_i, slip} = 2'h1;
    watch(20000, 1'b1);
    chk("sync lost", WORD_W'(1), WORD_W'(hit));
    slip = 1'b0;
    phase(1'b0, WORD_W'($urandom), WORD_W'($urandom));
    test_done();
  end
endmodule
